//--- verilog/rsssm_pkg.sv
// Package: constants, states and carrier structs of the reset sequencer and supply monitor
package rsssm_pkg;
	// Delay phase lengths in CPU clocks
	localparam int unsigned DELAY_SHORT_CYC = 256;
	localparam int unsigned DELAY_LONG_CYC = 4096;
	// Vector fetch phase length
	localparam int unsigned FETCH_CYC = 2;
	// Minimum watchdog reset output pulse, in ns, and its cycle count at 100 ns per clock
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned RST_OUT_MIN_NS = 20000;
	localparam int unsigned RST_OUT_MIN_CYC = (RST_OUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Default pll startup delay in ns
	localparam int unsigned PLL_STARTUP_NS = 100000;
	localparam int unsigned PLL_STARTUP_CYC = PLL_STARTUP_NS / CLK_PERIOD_NS;
	// Reset vector addresses
	localparam logic [15:0] RESET_VEC_LO = 16'hFFFE;
	localparam logic [15:0] RESET_VEC_HI = 16'hFFFF;
	// Counter width
	localparam int unsigned CNT_W = 13;
	// Clock source option codes
	localparam logic [1:0] CLKSRC_RC = 2'h0;
	localparam logic [1:0] CLKSRC_EXT = 2'h1;
	localparam logic [1:0] CLKSRC_XTAL = 2'h2;
	// Status reset values
	localparam logic RESET_FLAG_INIT = 1'h0;

	typedef enum {
		RSSM_ACTIVE,
		RSSM_DELAY,
		RSSM_FETCH,
		RSSM_PLL,
		RSSM_RUN
	} rsssm_state_e;

	// Option settings taken from the option bytes
	typedef struct packed {
		logic lvd_en;
		logic [1:0] lvd_level;
		logic [1:0] clk_src;
		logic pll_en;
	} rsssm_opt_s;

	// Supply integrity status as software sees it
	typedef struct packed {
		logic watchdog_reset_flag;
		logic low_voltage_reset_flag;
		logic supply_warning_flag;
		logic supply_warning_irq_enable;
	} rsssm_status_s;
endpackage

//--- verilog/rsssm_sync.sv
// Two flop synchroniser for one level
`timescale 1ns/1ps
module rsssm_sync #(
	parameter logic INIT = 1'h0
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic meta_r;

	// First stage read only by the second
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			meta_r <= INIT;
			q <= INIT;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // rsssm_sync

//--- verilog/rsssm_top.sv
// Reset sequence manager with low voltage and auxiliary supply monitoring
//
// Contract
// RQ1: Pin, low-voltage, watchdog resets start sequence
// RQ2: Illegal opcode or prebyte also resets
// RQ3: All sources drive pin; low during delay
// RQ4: Fetch vector from FFFEh-FFFFh after reset
// RQ5: Active, delay, then vector fetch phases
// RQ6: Delay 256 or 4096 by clock source
// RQ7: Vector fetch phase lasts two cycles
// RQ8: Pll adds startup delay before clock
// RQ9: Pin low detected without running clock
// RQ10: Reset pin is open-drain input/output
// RQ11: Hold pin low while supply low
// RQ12: Watchdog drives pin low minimum width
// RQ13: Detector optional, threshold option selectable
// RQ14: Supply warning flag is real-time read-only
// RQ15: Warning works only with detector enabled
// RQ16: Interrupt when warning flag becomes set
// RQ17: Request needs enable and clear mask
// RQ18: Wait unaffected; warning wakes from wait
// RQ19: Halt freezes status; no halt wake (code blocks only sw writes and read clears; hw flag sets still apply)
// RQ20: Watchdog flag: hw set, sw/low-voltage clear
// RQ21: Low-voltage flag set hw, cleared on read
// RQ22: Low-voltage flag survives other resets
// RQ23: Pending warning cleared on service entry
// RQ24: Synchronise reset request before delay count
`timescale 1ns/1ps
module rsssm_top #(
	parameter int unsigned DELAY_LONG = rsssm_pkg::DELAY_LONG_CYC,
	parameter int unsigned PLL_STARTUP = rsssm_pkg::PLL_STARTUP_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire rsssm_pkg::rsssm_opt_s opt,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	input wire logic pin_low_async,
	input wire logic lvd_below,
	input wire logic avd_below,
	input wire logic watchdog_underflow,
	input wire logic illegal_opcode,
	input wire logic irq_mask,
	input wire logic wait_mode,
	input wire logic halt_mode,
	input wire logic status_rd,
	input wire logic status_wr,
	input wire rsssm_pkg::rsssm_status_s status_wdata,
	input wire logic irq_ack,
	output rsssm_pkg::rsssm_status_s status,
	output logic supply_warning_irq,
	output logic wake_from_wait,
	output logic core_reset,
	output logic vector_fetch,
	output logic [15:0] vector_addr,
	output logic clock_out_en,
	output logic [1:0] lvd_threshold
);
	rsssm_pkg::rsssm_state_e state_r;
	logic [rsssm_pkg::CNT_W-1:0] cnt_r;
	logic [rsssm_pkg::CNT_W-1:0] delay_len;
	logic [rsssm_pkg::CNT_W-1:0] wd_cnt_r;
	logic [16:0] pll_cnt_r;
	logic pin_s;
	logic latch_s;
	logic lvd_s;
	logic avd_s;
	logic pin_low_latch_r;
	logic wd_req;
	logic lvd_req;
	logic ext_req;
	logic any_req;
	logic lvd_active;
	logic avd_prev_r;
	logic pend_r;
	logic wdf_r;
	logic lvdf_r;
	logic ie_r;
	logic warn_flag;
	logic pin_drive;
	logic [3:0] own_hist_r;
	logic own_mask;

	// Own drive echoes back through the synchronisers; mask it until the echo has drained
	always_ff @(posedge clock) begin
		if (!rst_n)
			own_hist_r <= 4'hF;
		else
			own_hist_r <= {own_hist_r[2:0], reset_pin_oe};
	end
	assign own_mask = reset_pin_oe | (|own_hist_r);

	// Async capture so a pin pulse is seen even with the clock halted
	always_latch begin
		if (!rst_n)
			pin_low_latch_r = 1'h0;
		else if (own_mask)
			pin_low_latch_r = 1'h0;
		else if (pin_low_async)
			pin_low_latch_r = 1'h1; // RQ9
	end

	// Every outside level crosses two flops first
	rsssm_sync u_sync_pin (.clock(clock), .rst_n(rst_n), .d(~reset_pin_in), .q(pin_s)); // RQ24
	rsssm_sync u_sync_latch (.clock(clock), .rst_n(rst_n), .d(pin_low_latch_r), .q(latch_s)); // RQ24
	rsssm_sync u_sync_lvd (.clock(clock), .rst_n(rst_n), .d(lvd_below), .q(lvd_s));
	rsssm_sync u_sync_avd (.clock(clock), .rst_n(rst_n), .d(avd_below), .q(avd_s));

	// Detector exists only when enabled by option
	assign lvd_active = opt.lvd_en; // RQ13
	assign lvd_threshold = opt.lvd_level; // RQ13
	assign lvd_req = lvd_active & lvd_s; // RQ1
	assign wd_req = watchdog_underflow | illegal_opcode; // RQ1 RQ2
	// Own drive reads back on the pin, so only count it as external once reset_pin_oe has been low for four cycles
	assign ext_req = (pin_s | latch_s) & ~own_mask; // RQ1
	assign any_req = lvd_req | wd_req | ext_req;

	// Delay picked from clock source
	always_comb begin
		if (opt.clk_src == rsssm_pkg::CLKSRC_XTAL)
			delay_len = rsssm_pkg::CNT_W'(DELAY_LONG); // RQ6
		else
			delay_len = rsssm_pkg::CNT_W'(rsssm_pkg::DELAY_SHORT_CYC); // RQ6
	end

	// Watchdog minimum pulse counter
	always_ff @(posedge clock) begin
		if (!rst_n)
			wd_cnt_r <= '0;
		else if (wd_req)
			wd_cnt_r <= rsssm_pkg::CNT_W'(rsssm_pkg::RST_OUT_MIN_CYC); // RQ12
		else if (wd_cnt_r != '0)
			wd_cnt_r <= wd_cnt_r - 1'b1;
	end

	// Phase sequencer; any new request restarts from active
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r <= rsssm_pkg::RSSM_ACTIVE;
			cnt_r <= '0;
		end else if (any_req || wd_cnt_r != '0) begin
			state_r <= rsssm_pkg::RSSM_ACTIVE; // RQ5
			cnt_r <= '0;
		end else begin
			case (state_r)
				rsssm_pkg::RSSM_ACTIVE: begin
					state_r <= rsssm_pkg::RSSM_DELAY; // RQ5
					cnt_r <= delay_len - 1'b1;
				end
				rsssm_pkg::RSSM_DELAY: begin
					if (cnt_r == '0) begin
						state_r <= rsssm_pkg::RSSM_FETCH; // RQ5
						cnt_r <= rsssm_pkg::CNT_W'(rsssm_pkg::FETCH_CYC - 1); // RQ7
					end else
						cnt_r <= cnt_r - 1'b1;
				end
				rsssm_pkg::RSSM_FETCH: begin
					if (cnt_r == '0)
						state_r <= opt.pll_en ? rsssm_pkg::RSSM_PLL : rsssm_pkg::RSSM_RUN; // RQ8
					else
						cnt_r <= cnt_r - 1'b1;
				end
				rsssm_pkg::RSSM_PLL: begin
					if (pll_cnt_r == 17'(PLL_STARTUP - 1))
						state_r <= rsssm_pkg::RSSM_RUN;
				end
				default: begin
					state_r <= rsssm_pkg::RSSM_RUN;
				end
			endcase
		end
	end

	// Pll startup counter
	always_ff @(posedge clock) begin
		if (!rst_n)
			pll_cnt_r <= '0;
		else if (state_r == rsssm_pkg::RSSM_PLL)
			pll_cnt_r <= pll_cnt_r + 1'b1; // RQ8
		else
			pll_cnt_r <= '0;
	end

	// Pin is driven low through active and delay phases
	assign pin_drive = (state_r == rsssm_pkg::RSSM_ACTIVE) || (state_r == rsssm_pkg::RSSM_DELAY)
		|| lvd_req || (wd_cnt_r != '0); // RQ3 RQ11 RQ12
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reset_pin_oe <= 1'h1;
		end else begin
			reset_pin_oe <= pin_drive | wd_req; // RQ3 RQ10
		end
	end
	assign reset_pin_out = 1'h0; // RQ10

	// Core controls from phase
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			core_reset <= 1'h1;
			vector_fetch <= 1'h0;
			vector_addr <= rsssm_pkg::RESET_VEC_LO;
			clock_out_en <= 1'h0;
		end else begin
			core_reset <= (state_r != rsssm_pkg::RSSM_RUN);
			vector_fetch <= (state_r == rsssm_pkg::RSSM_FETCH); // RQ4 RQ7
			vector_addr <= (state_r == rsssm_pkg::RSSM_FETCH && cnt_r == '0) ?
				rsssm_pkg::RESET_VEC_HI : rsssm_pkg::RESET_VEC_LO; // RQ4
			clock_out_en <= (state_r == rsssm_pkg::RSSM_RUN); // RQ8
		end
	end

	// Warning flag follows comparator live, gated by detector enable
	assign warn_flag = lvd_active & avd_s; // RQ14 RQ15

	// Enable bit and reset flags; halt blocks software writes and read clears, hardware flag sets still apply
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ie_r <= rsssm_pkg::RESET_FLAG_INIT;
			wdf_r <= rsssm_pkg::RESET_FLAG_INIT;
			lvdf_r <= rsssm_pkg::RESET_FLAG_INIT;
		end else begin
			if (lvd_req) begin
				lvdf_r <= 1'h1; // RQ21 RQ22
				wdf_r <= 1'h0; // RQ20
			end else if (wd_req) begin
				wdf_r <= 1'h1; // RQ20
			end else if (!halt_mode) begin // RQ19
				if (status_rd)
					lvdf_r <= 1'h0; // RQ21
				if (status_wr && !status_wdata.watchdog_reset_flag)
					wdf_r <= 1'h0; // RQ20
			end
			if (status_wr && !halt_mode)
				ie_r <= status_wdata.supply_warning_irq_enable;
		end
	end

	// Pending latch on flag rising edge; set beats service entry
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			avd_prev_r <= 1'h0;
			pend_r <= 1'h0;
		end else begin
			avd_prev_r <= warn_flag;
			if (warn_flag && !avd_prev_r && ie_r)
				pend_r <= 1'h1; // RQ16
			else if (irq_ack || !ie_r || !lvd_active)
				pend_r <= 1'h0; // RQ23 RQ15
		end
	end

	// Mask gates request; halt suppresses wake, wait does not
	assign supply_warning_irq = pend_r & ie_r & ~irq_mask & ~halt_mode; // RQ17 RQ19
	assign wake_from_wait = supply_warning_irq & wait_mode; // RQ18

	// Status view
	always_comb begin
		status.watchdog_reset_flag = wdf_r;
		status.low_voltage_reset_flag = lvdf_r;
		status.supply_warning_flag = warn_flag; // RQ14
		status.supply_warning_irq_enable = ie_r;
	end

	sequence s_fetch2;
		vector_fetch [*2] ##1 !vector_fetch;
	endsequence

	// No source is pending, so the phases may advance
	sequence s_quiet;
		!any_req && wd_cnt_r == '0;
	endsequence

	a_fetch_two: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(vector_fetch) |-> s_fetch2) else $error("vector fetch not two cycles"); // RQ7
	a_pin_delay: assert property (@(posedge clock) disable iff (!rst_n)
		$past(state_r == rsssm_pkg::RSSM_DELAY) |-> reset_pin_oe) else $error("pin released in delay"); // RQ3
	a_lvd_hold: assert property (@(posedge clock) disable iff (!rst_n)
		$past(lvd_req) |-> reset_pin_oe) else $error("pin not held in low supply"); // RQ11
	a_lvdf_set: assert property (@(posedge clock) disable iff (!rst_n)
		lvd_req |=> lvdf_r && !wdf_r) else $error("low voltage flags wrong"); // RQ20
	a_wdf_set: assert property (@(posedge clock) disable iff (!rst_n)
		wd_req && !lvd_req |=> wdf_r) else $error("watchdog flag not set"); // RQ20
	a_irq_mask: assert property (@(posedge clock) disable iff (!rst_n)
		supply_warning_irq |-> ie_r && !irq_mask) else $error("irq without enable"); // RQ17
	a_warn_gate: assert property (@(posedge clock) disable iff (!rst_n)
		!opt.lvd_en |-> !status.supply_warning_flag) else $error("warning without detector"); // RQ15
	a_vec_addr: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(vector_fetch) |-> vector_addr == rsssm_pkg::RESET_VEC_LO ##1 vector_addr == rsssm_pkg::RESET_VEC_HI)
		else $error("vector address wrong"); // RQ4
	a_wd_pulse: assert property (@(posedge clock) disable iff (!rst_n)
		wd_req |=> reset_pin_oe [*8]) else $error("watchdog pulse too short"); // RQ12
	// Any source restarts the active phase
	a_src_restart: assert property (@(posedge clock) disable iff (!rst_n) // RQ1
		any_req |=> state_r == rsssm_pkg::RSSM_ACTIVE)
		else $error("source did not restart sequence");
	// Delay counter loaded from the clock source choice
	a_delay_load: assert property (@(posedge clock) disable iff (!rst_n) // RQ6
		(state_r == rsssm_pkg::RSSM_ACTIVE) ##0 s_quiet |=> state_r == rsssm_pkg::RSSM_DELAY && cnt_r == $past(delay_len) - 1'b1)
		else $error("delay length wrong");
	// Delay end leads to vector fetch
	a_fetch_next: assert property (@(posedge clock) disable iff (!rst_n) // RQ5
		(state_r == rsssm_pkg::RSSM_DELAY && cnt_r == '0) ##0 s_quiet |=> state_r == rsssm_pkg::RSSM_FETCH)
		else $error("fetch did not follow delay");
	// Pll option inserts the startup wait
	a_pll_wait: assert property (@(posedge clock) disable iff (!rst_n) // RQ8
		(opt.pll_en && state_r == rsssm_pkg::RSSM_FETCH && cnt_r == '0) ##0 s_quiet |=> state_r == rsssm_pkg::RSSM_PLL)
		else $error("pll startup skipped");
	// Clock only given out once running
	a_clk_gate: assert property (@(posedge clock) disable iff (!rst_n) // RQ8
		clock_out_en |-> $past(state_r == rsssm_pkg::RSSM_RUN))
		else $error("clock out before run");
	// Core held until the sequence has run through
	a_core_hold: assert property (@(posedge clock) disable iff (!rst_n) // RQ5
		state_r != rsssm_pkg::RSSM_RUN |=> core_reset)
		else $error("core released early");
	// Open drain never drives high
	a_pin_drain: assert property (@(posedge clock) disable iff (!rst_n) // RQ10
		reset_pin_out == 1'h0)
		else $error("reset pin driven high");
	// Disabled detector cannot reset
	a_lvd_gate: assert property (@(posedge clock) disable iff (!rst_n) // RQ13
		!opt.lvd_en |-> !lvd_req)
		else $error("detector active while disabled");
	// Watchdog pulse counter keeps the pin low
	a_wd_hold: assert property (@(posedge clock) disable iff (!rst_n) // RQ12
		wd_cnt_r != '0 |=> reset_pin_oe)
		else $error("pin released in watchdog pulse");
	// Low-voltage flag only leaves on a read
	a_lvdf_keep: assert property (@(posedge clock) disable iff (!rst_n) // RQ22
		lvdf_r && !status_rd |=> lvdf_r)
		else $error("low voltage flag lost");
	// Rising warning latches a pending request
	a_pend_set: assert property (@(posedge clock) disable iff (!rst_n) // RQ16
		warn_flag && !avd_prev_r && ie_r |=> pend_r)
		else $error("warning not latched");
	// Service entry drops the pending request
	a_ack_clear: assert property (@(posedge clock) disable iff (!rst_n) // RQ23
		irq_ack && !(warn_flag && !avd_prev_r && ie_r) |=> !pend_r)
		else $error("pending kept after service entry");
	// Halt freezes the enable and keeps the request quiet
	a_halt_freeze: assert property (@(posedge clock) disable iff (!rst_n) // RQ19
		halt_mode |=> ie_r == $past(ie_r) && !$past(supply_warning_irq))
		else $error("register changed in halt");
	// Request in wait wakes the core
	a_wait_wake: assert property (@(posedge clock) disable iff (!rst_n) // RQ18
		supply_warning_irq && wait_mode |-> wake_from_wait)
		else $error("no wake from wait");
endmodule // rsssm_top

//--- tb/rsssm_pin_model.sv
// Far side of the reset pin: board pull-up and external reset circuit
`timescale 1ns/1ps
module rsssm_pin_model (
	input wire logic dev_oe,
	input wire logic ext_low,
	output logic pin_level,
	output logic pin_low_async
);
	// Open-drain wire, either party pulls low, pull-up otherwise
	assign pin_level = ~(dev_oe | ext_low);
	// Clockless low detector sees the wire itself
	assign pin_low_async = ~pin_level;
endmodule // rsssm_pin_model

//--- tb/testbench.sv
// Self-checking bench of the reset sequencer and supply monitor
`timescale 1ns/1ps
module testbench;
	logic clock = 1'h0;
	logic rst_n = 1'h0;
	rsssm_pkg::rsssm_opt_s opt = '0;
	rsssm_pkg::rsssm_status_s status;
	logic [3:0] wdata = 4'h0;
	logic ext_low = 1'h0, lvd_b = 1'h0, avd_b = 1'h0, wdog = 1'h0, ill = 1'h0, mask = 1'h1;
	logic waitm = 1'h0, rd = 1'h0, wr = 1'h0, ack = 1'h0, haltm = 1'h0;
	logic pin_in, pin_out, oe, low_async, irq, wake, core_reset, vfetch, clk_en;
	logic [15:0] vaddr;
	logic [1:0] thr;
	int fails = 0;
	int tests_run = 0;

	// Clock at 100 ns
	always #50 clock = ~clock;

	rsssm_pin_model pin (.dev_oe(oe), .ext_low(ext_low), .pin_level(pin_in), .pin_low_async(low_async));

	// Short long-delay keeps the crystal case quick
	rsssm_top #(.DELAY_LONG(16), .PLL_STARTUP(8)) DUT (.clock(clock), .rst_n(rst_n), .opt(opt),
		.reset_pin_in(pin_in), .reset_pin_out(pin_out), .reset_pin_oe(oe), .pin_low_async(low_async),
		.lvd_below(lvd_b), .avd_below(avd_b), .watchdog_underflow(wdog), .illegal_opcode(ill),
		.irq_mask(mask), .wait_mode(waitm), .halt_mode(haltm), .status_rd(rd), .status_wr(wr),
		.status_wdata(wdata), .irq_ack(ack), .status(status), .supply_warning_irq(irq),
		.wake_from_wait(wake), .core_reset(core_reset), .vector_fetch(vfetch), .vector_addr(vaddr),
		.clock_out_en(clk_en), .lvd_threshold(thr));

	task automatic conclude();
		if (fails == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask

	// Bounded wait for the core to leave reset
	task automatic wait_run();
		int c;
		c = 0;
		// Core reset is registered, so let a new request reach it first
		tick(2);
		while (core_reset !== 1'h0 && c < 9000) begin
			tick(1);
			c++;
		end
		if (c >= 9000) begin
			fails++;
			conclude();
		end
	endtask

	// Delay length, pin drive, then two fetch cycles with fixed addresses
	task automatic run_seq(input int n);
		int c;
		c = 0;
		tick(2);
		cmp(16'(oe), 16'h1);
		while (vfetch !== 1'h1 && c < 6000) begin
			tick(1);
			c++;
		end
		if (c >= 6000) begin
			fails++;
			conclude();
		end
		cmp(16'(c >= n - 2 && c <= n + 4), 16'h1);
		cmp(vaddr, rsssm_pkg::RESET_VEC_LO);
		tick(1);
		cmp(16'(vfetch), 16'h1);
		cmp(vaddr, rsssm_pkg::RESET_VEC_HI);
		tick(1);
		cmp(16'(vfetch), 16'h0);
		wait_run();
	endtask

	task automatic pulse(ref logic s);
		s = 1'h1;
		tick(1);
		s = 1'h0;
	endtask

	// Power-up on internal RC, then external pin reset on crystal
	task automatic t_pin();
		run_seq(256);
		opt.clk_src = rsssm_pkg::CLKSRC_XTAL;
		ext_low = 1'h1;
		tick(3);
		ext_low = 1'h0;
		run_seq(16);
		cmp(16'(status), 16'h0);
	endtask

	// Watchdog holds pin for the minimum pulse; illegal opcode acts alike
	task automatic t_wdog();
		int c;
		c = 0;
		pulse(wdog);
		while (oe === 1'h1 && c < 900) begin
			tick(1);
			c++;
		end
		cmp(16'(c >= rsssm_pkg::RST_OUT_MIN_CYC - 2), 16'h1);
		wait_run();
		cmp(16'(status.watchdog_reset_flag), 16'h1);
		wdata = 4'h0;
		pulse(wr);
		cmp(16'(status.watchdog_reset_flag), 16'h0);
		pulse(ill);
		wait_run();
		cmp(16'(status.watchdog_reset_flag), 16'h1);
	endtask

	// Supply low holds pin; flag survives watchdog, cleared by read
	task automatic t_lvd();
		opt.lvd_en = 1'h1;
		lvd_b = 1'h1;
		tick(30);
		cmp(16'(oe), 16'h1);
		lvd_b = 1'h0;
		wait_run();
		cmp(16'(status[3:2]), 16'h1);
		pulse(wdog);
		wait_run();
		cmp(16'(status.low_voltage_reset_flag), 16'h1);
		pulse(rd);
		tick(1);
		cmp(16'(status.low_voltage_reset_flag), 16'h0);
		for (int l = 0; l < 3; l++) begin
			opt.lvd_level = 2'(l);
			tick(1);
			cmp(16'(thr), 16'(l));
		end
	endtask

	// Warning flag, interrupt gating, service entry and wait wake-up
	task automatic t_avd();
		wdata = 4'h1;
		pulse(wr);
		mask = 1'h0;
		waitm = 1'h1;
		avd_b = 1'h1;
		tick(4);
		cmp(16'(status.supply_warning_flag), 16'h1);
		cmp(16'({irq, wake}), 16'h3);
		mask = 1'h1;
		tick(1);
		cmp(16'(irq), 16'h0);
		mask = 1'h0;
		pulse(ack);
		tick(1);
		cmp(16'(irq), 16'h0);
		haltm = 1'h1;
		wdata = 4'h0;
		pulse(wr);
		cmp(16'(status.supply_warning_irq_enable), 16'h1);
		haltm = 1'h0;
		avd_b = 1'h0;
		tick(4);
		avd_b = 1'h1;
		opt.lvd_en = 1'h0;
		tick(4);
		cmp(16'({status.supply_warning_flag, irq}), 16'h0);
	endtask

	// Pll option holds clock and core past the fetch
	task automatic t_pll();
		int c;
		c = 0;
		opt.pll_en = 1'h1;
		pulse(ext_low);
		tick(3);
		while (vfetch !== 1'h1 && c < 900) begin
			tick(1);
			c++;
		end
		if (c >= 900) begin
			fails++;
			conclude();
		end
		tick(2);
		cmp(16'({clk_en, core_reset}), 16'h1);
		wait_run();
		cmp(16'({clk_en, pin_out}), 16'h2);
	endtask

	initial begin
		tick(16);
		rst_n = 1'h1;
		t_pin();
		t_wdog();
		t_lvd();
		t_avd();
		t_pll();
		conclude();
	end
endmodule // testbench
